// ---- dv/testbench.sv ----
module testbench import zc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
   // bench drive, all valued at time zero
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, clamp, other, absr, pa;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic signed [15:0] ref_set = 16'sh0, sref, cmd;
   logic [2:0] pin_set = 3'b000, pins;
   logic signed [31:0] fb = 32'sh0;
   logic [1:0] mode = 2'b00;
   zc_enc_t enc;
   int fail_count = 0, n_tests = 0, nc, na;
   // {write, addr, wdata, expected}: reset values, then range filtering
   logic [43:0] tbl [15] = '{44'h0_00_0000_0000, 44'h0_04_0000_000A, 44'h0_08_0000_0258, 44'h0_0C_0000_1388,
      44'h0_10_0000_0040, 44'h0_14_0000_0001, 44'h0_18_0000_0000, 44'h0_1C_0000_0000, 44'h0_30_0000_0000,
      44'h1_04_2711_000A, 44'h1_04_2710_2710, 44'h1_08_0095_0258, 44'h1_08_0BB8_0BB8, 44'h1_08_0258_0258,
      44'h1_30_FFFF_0000};
   // {ctrl, mode, clamp expected} under per-signal allocation
   logic [15:0] dig [14] = '{16'h30_0_1, 16'h33_0_1, 16'h34_0_1, 16'h35_0_1, 16'h36_0_1, 16'h37_0_1, 16'h39_0_1,
      16'h31_0_0, 16'h32_0_0, 16'h38_0_0, 16'h3A_0_0, 16'h10_0_0, 16'h37_1_0, 16'h39_2_0};
   zc_clamp #(.POS_W(32), .REF_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .prop_ctrl_input_i(pins[0]),
      .clamp_request_input_i(pins[1]), .abs_data_request_i(pins[2]), .speed_ref_i(sref), .fb_pos_i(fb),
      .active_mode_i(mode), .speed_cmd_o(cmd), .clamp_active_o(clamp), .prop_ctrl_other_o(other),
      .abs_req_o(absr), .enc_o(enc));
   zc_host host (.clk_i(clk_i), .rst_i(rst_i), .ref_set_i(ref_set), .pin_set_i(pin_set), .speed_ref_o(sref),
      .pin_o(pins));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // one classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
         fail_count++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog well past the roughly 1750 cycles the tests need
   initial begin
      wait_cyc(20000);
      fail_count++;
      wrap_up();
   end
   initial begin
      wait_cyc(12);
      rst_i <= 1'b0;
      foreach (tbl[i]) begin
         if (tbl[i][40])
            wb(1'b1, tbl[i][39:32], {16'h0, tbl[i][31:16]});
         wb(1'b0, tbl[i][39:32], 32'h0);
         `CHK(q, {16'h0, tbl[i][15:0]})
      end
      // proportional pin as clamp request, then a push away and release
      wb(1'b1, ZC_A_CTRL, 32'h0A);
      fb <= 32'sd100;
      ref_set <= 16'sd1;
      pin_set <= 3'b001;
      wait_cyc(8);
      `CHK(clamp, 1'b1)
      `CHK(other, 1'b0)
      wb(1'b0, ZC_A_TARGET, 32'h0);
      `CHK(q, 32'd100)
      fb <= 32'sd90;
      wait_cyc(4);
      `CHK(cmd, 16'sd40)
      fb <= 32'sd100;
      ref_set <= 16'sd1000;
      wait_cyc(4);
      `CHK(cmd, 16'sd0)
      pin_set <= 3'b000;
      ref_set <= 16'sd1234;
      wait_cyc(6);
      `CHK(clamp, 1'b0)
      `CHK(cmd, 16'sd1234)
      // level 200 above motor maximum: 100 mm/s governs
      wb(1'b1, ZC_A_LEVEL, 32'd200);
      wb(1'b1, ZC_A_MAXSPD, 32'd100);
      ref_set <= 16'sd700;
      pin_set <= 3'b001;
      wait_cyc(8);
      `CHK(clamp, 1'b0)
      ref_set <= 16'sd500;
      wait_cyc(8);
      `CHK(clamp, 1'b1)
      pin_set <= 3'b000;
      foreach (dig[i]) begin
         wb(1'b1, ZC_A_CTRL, {24'h0, dig[i][15:8]});
         mode <= dig[i][5:4];
         ref_set <= 16'sd0;
         pin_set <= 3'b010;
         wait_cyc(8);
         `CHK(clamp, dig[i][0])
         pin_set <= 3'b000;
         mode <= 2'd0;
         wait_cyc(6);
      end
      wb(1'b1, ZC_A_CTRL, 32'h0);
      pin_set <= 3'b101;
      wait_cyc(6);
      `CHK(other, 1'b1)
      `CHK(clamp, 1'b0)
      `CHK(absr, 1'b1)
      pin_set <= 3'b000;
      // phase C positions crossed once, single then dual with reverse setting
      wb(1'b1, ZC_A_CWIDTH, 32'd4);
      wb(1'b1, ZC_A_CPOS0, 32'h200);
      wb(1'b1, ZC_A_CPOS1, 32'h210);
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, ZC_A_CTRL, (k == 0) ? 32'h00 : 32'hC0);
         fb <= 32'sh1F0;
         wait_cyc(600);
         nc = 0;
         na = 0;
         pa = enc.a;
         fb <= 32'sh220;
         repeat (80) begin
            @(posedge clk_i);
            if (enc.c === 1'b1)
               nc++;
            if (enc.a === 1'b1 && pa === 1'b0)
               na++;
            pa = enc.a;
         end
         `CHK(nc, 4 * (k + 1))
         `CHK(na, 12)
      end
      wrap_up();
   end
endmodule // testbench

// ---- dv/zc_clamp_chk.sv ----
module zc_clamp_chk
   import zc_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int REF_W = 16
) (
   // clock, reset and bus handshake
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // host pins and reference
   input wire logic prop_ctrl_input_i,
   input wire logic clamp_request_input_i,
   input wire logic abs_data_request_i,
   input wire logic signed [REF_W-1:0] speed_ref_i,
   // drive outputs
   input wire logic signed [REF_W-1:0] speed_cmd_o,
   input wire logic clamp_active_o,
   input wire logic prop_ctrl_other_o,
   input wire logic abs_req_o,
   input wire zc_enc_t enc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // either clamp pin; pins pass two sync stages plus the state stage
   logic req_any;
   assign req_any = prop_ctrl_input_i | clamp_request_input_i;
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   // only judged where the state was steady around the sampled command
   property p_follow; !clamp_active_o && !$past(clamp_active_o) && !$past(clamp_active_o, 2) && !$past(rst_i)
      && !$past(rst_i, 2)
      |-> $past(speed_cmd_o) == $past(speed_ref_i, 2); endproperty
   a_follow: assert property (p_follow) else $error("command does not follow reference");
   property p_release; (!prop_ctrl_input_i && !clamp_request_input_i) [*4] |-> !clamp_active_o; endproperty
   a_release: assert property (p_release) else $error("clamp kept without request");
   property p_entry; $rose(clamp_active_o) |-> $past(req_any, 3); endproperty
   a_entry: assert property (p_entry) else $error("clamp entered without request");
   property p_other; prop_ctrl_other_o |-> $past(prop_ctrl_input_i, 3); endproperty
   a_other: assert property (p_other) else $error("other function seen without pin");
   property p_abs; $rose(abs_req_o) |-> $past(abs_data_request_i, 2); endproperty
   a_abs: assert property (p_abs) else $error("abs request without pin");
   property p_diff; enc_o.a != enc_o.a_n && enc_o.b != enc_o.b_n && enc_o.c != enc_o.c_n; endproperty
   a_diff: assert property (p_diff) else $error("encoder pair not complementary");
   property p_quad; !($changed(enc_o.a) && $changed(enc_o.b)); endproperty
   a_quad: assert property (p_quad) else $error("phases A and B moved together");
   c_clamp_on: cover property ($rose(clamp_active_o));
   c_clamp_off: cover property ($fell(clamp_active_o));
   c_phase_c: cover property ($rose(enc_o.c));
endmodule // zc_clamp_chk

bind zc_clamp zc_clamp_chk #(.POS_W(POS_W), .REF_W(REF_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .prop_ctrl_input_i(prop_ctrl_input_i), .clamp_request_input_i(clamp_request_input_i),
   .abs_data_request_i(abs_data_request_i), .speed_ref_i(speed_ref_i), .speed_cmd_o(speed_cmd_o),
   .clamp_active_o(clamp_active_o), .prop_ctrl_other_o(prop_ctrl_other_o), .abs_req_o(abs_req_o), .enc_o(enc_o));

// ---- dv/zc_host.sv ----
module zc_host (
   // clock and commands from the bench
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic signed [15:0] ref_set_i,
   input wire logic [2:0] pin_set_i,
   // toward the drive: reference and pins {abs, clamp_request_input, pcon}
   output logic signed [15:0] speed_ref_o,
   output logic [2:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // host output stage changes just after an edge, so the drive syncs cleanly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_ref_o <= '0;
         pin_o <= '0;
      end else begin
         speed_ref_o <= ref_set_i;
         pin_o <= pin_set_i;
      end
   end
endmodule // zc_host

// ---- hdl/zc_clamp.sv ----
// How it works
// - clamp on request and low reference
// - hold within one feedback pulse
// - drive back displaced motor to target
// - inactive request follows speed reference
// - allocation 0 takes prop_ctrl_input, digit A
// - digit A dedicates prop_ctrl_input to clamp
// - allocation 1 uses mapped clamp_request_input
// - allocation 1 only digits 0,3-7,9
// - switchable digits clamp only in speed
// - level 0..10000 mm/s, default 10, immediate
// - level capped at motor maximum speed
// - phase A/B/C pulses from feedback
// - phase C width follows width setting
// - phase form independent of direction select
// - phase C at two zero positions
// - reference gain 150..3000, default 600
module zc_clamp
   import zc_pkg::*;
#(
   parameter int POS_W = 32,
   parameter int REF_W = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // host pins, asynchronous
   input wire logic prop_ctrl_input_i,
   input wire logic clamp_request_input_i,
   input wire logic abs_data_request_i,
   // drive-internal signals on clk_i
   input wire logic signed [REF_W-1:0] speed_ref_i,
   input wire logic signed [POS_W-1:0] fb_pos_i,
   input wire logic [1:0] active_mode_i,
   // speed command to the speed loop, clamp and pin status
   output logic signed [REF_W-1:0] speed_cmd_o,
   output logic clamp_active_o,
   output logic prop_ctrl_other_o,
   output logic abs_req_o,
   // encoder pulse outputs
   output zc_enc_t enc_o
);
   // all state
   typedef struct packed {
      logic [31:0] dat;
      logic ack;
      logic [7:0] ctrl;
      logic [13:0] level;
      logic [11:0] gain;
      logic [15:0] maxspd;
      logic [15:0] kp;
      logic [7:0] cwidth;
      logic [15:0] cpos0;
      logic [15:0] cpos1;
      zc_state_t st;
      logic signed [POS_W-1:0] target;
      logic signed [REF_W-1:0] cmd;
      logic [1:0] pc_s;
      logic [1:0] cr_s;
      logic [1:0] ab_s;
      logic [1:0] ph;
      logic signed [POS_W-1:0] last_pos;
      logic [7:0] ccnt;
      logic cout;
      logic enc_out_c;
      zc_enc_t enc;
   } zc_st_t;

   zc_st_t s; // registered state
   zc_st_t n; // next state

   // speed of the reference scaled to mm/s, magnitude only
   function automatic logic [31:0] ref_speed(input logic signed [REF_W-1:0] r, input logic [11:0] g,
                                             input logic [15:0] mx);
      logic [31:0] mag;
      logic [47:0] p;
      mag = (r < 0) ? 32'(-r) : 32'(r);
      // reference counts in 0.01 V; motor maximum speed, not rated speed, reached at gain counts
      p = 48'(mag) * 48'(mx);
      ref_speed = (g == 12'h000) ? 32'hFFFFFFFF : 32'(p / 48'(g));
   endfunction

   // clamp allowed for this method digit under allocation 1
   function automatic logic digit_ok(input logic [3:0] d);
      digit_ok = (d == ZC_CM_SPEED) || (d == ZC_CM_INT3) || (d == ZC_CM_INT4) || (d == ZC_CM_SW5) ||
                 (d == ZC_CM_SW6) || (d == ZC_CM_SW7) || (d == ZC_CM_SW9);
   endfunction

   // saturating 16-bit clip
   function automatic logic signed [REF_W-1:0] clip(input logic signed [POS_W+16:0] v);
      logic signed [POS_W+16:0] hi;
      hi = (POS_W+17)'(2 ** (REF_W-1) - 1);
      if (v > hi) clip = REF_W'(hi);
      else if (v < -hi) clip = REF_W'(-hi);
      else clip = REF_W'(v);
   endfunction

   logic [3:0] digit;
   logic [13:0] eff_level;
   logic req;
   logic enabled;
   logic below;
   logic signed [POS_W-1:0] err;
   logic signed [POS_W-1:0] step;
   logic fwd_step;
   logic rev_step;
   logic at_zero;

   // decode, qualify and drive the next state
   always_comb begin
      n = s;
      digit = s.ctrl[ZC_F_CM +: 4];
      // effective level is capped at maximum speed
      eff_level = (16'(s.level) > s.maxspd) ? s.maxspd[13:0] : s.level;
      // request source follows input allocation
      if (!s.ctrl[ZC_F_ALLOC]) begin
         req = s.pc_s[1] && (digit == ZC_CM_PCON);
      end else begin
         req = s.cr_s[1] && s.ctrl[ZC_F_MAPPED] && digit_ok(digit);
      end
      enabled = req;
      // switchable methods only clamp while in speed mode
      if (s.ctrl[ZC_F_ALLOC] && ((digit == ZC_CM_SW5) || (digit == ZC_CM_SW6) || (digit == ZC_CM_SW7) ||
                                 (digit == ZC_CM_SW9)) && (active_mode_i != ZC_MODE_SPEED)) begin
         enabled = 1'b0;
      end
      below = ref_speed(speed_ref_i, s.gain, s.maxspd) < 32'(eff_level);
      err = s.target - fb_pos_i;

      // wishbone: one-cycle answer, ack drops after one cycle
      n.ack = cyc_i && stb_i && !s.ack;
      n.dat = 32'h00000000;
      if (cyc_i && stb_i && !s.ack) begin
         if (adr_i == ZC_A_CTRL) begin
            n.dat = {24'h000000, s.ctrl};
            if (we_i && sel_i[0]) n.ctrl = dat_i[7:0];
         end else if (adr_i == ZC_A_LEVEL) begin
            n.dat = {18'h00000, s.level};
            // out-of-range writes are ignored
            if (we_i && (&sel_i[1:0]) && (dat_i[13:0] <= ZC_LEVEL_MAX) && (dat_i[31:14] == 18'h0)) begin
               n.level = dat_i[13:0];
            end
         end else if (adr_i == ZC_A_GAIN) begin
            n.dat = {20'h00000, s.gain};
            if (we_i && (&sel_i[1:0]) && (dat_i[11:0] >= ZC_GAIN_MIN) && (dat_i[11:0] <= ZC_GAIN_MAX) &&
                (dat_i[31:12] == 20'h0)) begin
               n.gain = dat_i[11:0];
            end
         end else if (adr_i == ZC_A_MAXSPD) begin
            n.dat = {16'h0000, s.maxspd};
            if (we_i && (&sel_i[1:0])) n.maxspd = dat_i[15:0];
         end else if (adr_i == ZC_A_KP) begin
            n.dat = {16'h0000, s.kp};
            if (we_i && (&sel_i[1:0])) n.kp = dat_i[15:0];
         end else if (adr_i == ZC_A_CWIDTH) begin
            n.dat = {24'h000000, s.cwidth};
            if (we_i && sel_i[0]) n.cwidth = (dat_i[7:0] == 8'h00) ? 8'h01 : dat_i[7:0];
         end else if (adr_i == ZC_A_CPOS0) begin
            n.dat = {16'h0000, s.cpos0};
            if (we_i && (&sel_i[1:0])) n.cpos0 = dat_i[15:0];
         end else if (adr_i == ZC_A_CPOS1) begin
            n.dat = {16'h0000, s.cpos1};
            if (we_i && (&sel_i[1:0])) n.cpos1 = dat_i[15:0];
         end else if (adr_i == ZC_A_STATUS) begin
            n.dat = {27'h0000000, s.ab_s[1], s.cr_s[1], s.pc_s[1], s.st == ZC_ST_CLAMP, enabled};
         end else if (adr_i == ZC_A_TARGET) begin
            n.dat = 32'(s.target);
         end else begin
            // unmapped: acked, reads zero, writes dropped
            n.dat = 32'h00000000;
         end
      end

      // two-stage synchronisers for host pins
      n.pc_s = {s.pc_s[0], prop_ctrl_input_i};
      n.cr_s = {s.cr_s[0], clamp_request_input_i};
      n.ab_s = {s.ab_s[0], abs_data_request_i};

      // clamp state machine
      case (s.st)
         ZC_ST_FOLLOW: begin
            n.cmd = speed_ref_i;
            if (enabled && below) begin
               n.st = ZC_ST_CLAMP;
               n.target = fb_pos_i;
            end
         end
         ZC_ST_CLAMP: begin
            // proportional position loop, reference ignored
            n.cmd = clip((POS_W+17)'(err) * (POS_W+17)'($signed({1'b0, s.kp})) >>> 4);
            // release on request drop; reference rising stays held by design choice
            if (!enabled) begin
               n.st = ZC_ST_FOLLOW;
               n.cmd = speed_ref_i;
            end
         end
         default: begin
            n.st = ZC_ST_FOLLOW;
         end
      endcase

      // quadrature from feedback steps, one count per edge
      step = fb_pos_i - s.last_pos;
      fwd_step = step > 0;
      rev_step = step < 0;
      if (fwd_step) begin
         n.ph = s.ph + 2'd1;
         n.last_pos = s.last_pos + 1;
      end else if (rev_step) begin
         n.ph = s.ph - 2'd1;
         n.last_pos = s.last_pos - 1;
      end
      // direction select is deliberately not applied
      // phase C at one or two zero positions, width in counts
      at_zero = (fwd_step || rev_step) && ((n.last_pos[15:0] == s.cpos0) ||
                (s.ctrl[ZC_F_DUALC] && (n.last_pos[15:0] == s.cpos1)));
      if (at_zero) begin
         n.ccnt = s.cwidth;
      end else if ((fwd_step || rev_step) && (s.ccnt != 8'h00)) begin
         n.ccnt = s.ccnt - 8'd1;
      end
      n.enc_out_c = (n.ccnt != 8'h00);
      // gray sequence: 00,01,11,10 for A,B
      n.enc.a = n.ph[1] ^ 1'b0;
      n.enc.b = n.ph[1] ^ n.ph[0];
      n.enc.a_n = ~n.enc.a;
      n.enc.b_n = ~n.enc.b;
      n.enc.c = n.enc_out_c;
      n.enc.c_n = ~n.enc_out_c;
      // prop input is routed elsewhere only when not dedicated to clamp
      n.cout = s.pc_s[1] && (digit != ZC_CM_PCON);
   end

   // single state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.ctrl <= {4'h0, ZC_CM_RST};
         s.level <= ZC_LEVEL_RST;
         s.gain <= ZC_GAIN_RST;
         s.maxspd <= ZC_MAXSPD_RST;
         s.kp <= ZC_KP_RST;
         s.cwidth <= ZC_CWIDTH_RST;
         s.cpos0 <= ZC_CPOS_RST;
         s.cpos1 <= ZC_CPOS_RST;
         s.st <= ZC_ST_FOLLOW;
         s.enc <= 6'b010101;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state register
   assign dat_o = s.dat;
   assign ack_o = s.ack;
   assign speed_cmd_o = s.cmd;
   // one-hot clamp bit is itself a flip-flop
   assign clamp_active_o = s.st[1];
   // registered copy, costs one more cycle of pin latency
   assign prop_ctrl_other_o = s.cout;
   assign abs_req_o = s.ab_s[1];
   assign enc_o = s.enc;
endmodule // zc_clamp

// ---- hdl/zc_pkg.sv ----
package zc_pkg;
   // speed reference gain, 0.01 V per motor maximum speed
   localparam logic [11:0] ZC_GAIN_MIN = 12'd150;
   localparam logic [11:0] ZC_GAIN_MAX = 12'd3000;
   localparam logic [11:0] ZC_GAIN_RST = 12'd600;
   // clamp level in mm/s
   localparam logic [13:0] ZC_LEVEL_MAX = 14'd10000;
   localparam logic [13:0] ZC_LEVEL_RST = 14'd10;
   // control method digits
   localparam logic [3:0] ZC_CM_SPEED = 4'h0;
   localparam logic [3:0] ZC_CM_INT3 = 4'h3;
   localparam logic [3:0] ZC_CM_INT4 = 4'h4;
   localparam logic [3:0] ZC_CM_SW5 = 4'h5;
   localparam logic [3:0] ZC_CM_SW6 = 4'h6;
   localparam logic [3:0] ZC_CM_SW7 = 4'h7;
   localparam logic [3:0] ZC_CM_SW9 = 4'h9;
   localparam logic [3:0] ZC_CM_PCON = 4'hA;
   localparam logic [3:0] ZC_CM_RST = 4'h0;
   // other configuration resets
   localparam logic [15:0] ZC_MAXSPD_RST = 16'd5000;
   localparam logic [7:0] ZC_CWIDTH_RST = 8'h01;
   localparam logic [15:0] ZC_KP_RST = 16'h0040;
   localparam logic [15:0] ZC_CPOS_RST = 16'h0000;
   // register offsets, byte addresses
   localparam logic [7:0] ZC_A_CTRL = 8'h00;
   localparam logic [7:0] ZC_A_LEVEL = 8'h04;
   localparam logic [7:0] ZC_A_GAIN = 8'h08;
   localparam logic [7:0] ZC_A_MAXSPD = 8'h0C;
   localparam logic [7:0] ZC_A_KP = 8'h10;
   localparam logic [7:0] ZC_A_CWIDTH = 8'h14;
   localparam logic [7:0] ZC_A_CPOS0 = 8'h18;
   localparam logic [7:0] ZC_A_CPOS1 = 8'h1C;
   localparam logic [7:0] ZC_A_STATUS = 8'h20;
   localparam logic [7:0] ZC_A_TARGET = 8'h24;
   // ctrl field positions
   localparam int ZC_F_CM = 0;
   localparam int ZC_F_ALLOC = 4;
   localparam int ZC_F_MAPPED = 5;
   localparam int ZC_F_DIR = 6;
   localparam int ZC_F_DUALC = 7;
   // active control mode of a switchable method
   typedef enum logic [1:0] {ZC_MODE_SPEED = 2'h0, ZC_MODE_POS = 2'h1, ZC_MODE_FORCE = 2'h2,
                             ZC_MODE_INT = 2'h3} zc_mode_t;
   // clamp state machine, one-hot
   typedef enum logic [1:0] {ZC_ST_FOLLOW = 2'b01, ZC_ST_CLAMP = 2'b10} zc_state_t;
   // encoder pulse outputs
   typedef struct packed {
      logic a;
      logic a_n;
      logic b;
      logic b_n;
      logic c;
      logic c_n;
   } zc_enc_t;
endpackage : zc_pkg
